// File: src/lcb_consts.svh
// command opcodes, field positions, reset values and timing ratios
// assumes inclusion by the command/blink timing block and its bench
`ifndef LCB_CONSTS_SVH
`define LCB_CONSTS_SVH
`define LCB_CONT_BIT 7
`define LCB_PTR_MAX 6'h27
`define LCB_OP_SEL 5'h18
`define LCB_OP_BANK 5'h1E
`define LCB_OP_BLINK 4'hE
`define LCB_OP_MODE 2'h2
`define LCB_MODE_EN_BIT 3
`define LCB_MODE_BIAS_BIT 2
`define LCB_BANK_IN_BIT 1
`define LCB_BANK_OUT_BIT 0
`define LCB_BLINK_AB_BIT 2
`define LCB_FRAME_DIV 24
`define LCB_BLINK_DIV1 768
`define LCB_BLINK_DIV2 1536
`define LCB_BLINK_DIV3 3072
`define LCB_RST_MODE 2'h1
`endif

// File: src/lcb_core.sv
// command decoder, clock select, frame timing and blink generator
// assumes bytes arrive decoded from the serial bus as one-cycle strobes
`timescale 1ns/10ps
`default_nettype none
`include "lcb_consts.svh"

// Function
// R1: bit6 clear loads six-bit ram pointer; host keeps it 0..39
// R2: opcode 11000 loads two-bit subaddress counter
// R3: bank bit1 picks input rows, low or upper pair
// R4: bank bit0 picks output rows, low or upper pair
// R5: bank command ignored in 1:3 and 1:4 modes
// R6: opcode 1110 is blink; bit2 picks alternate-bank blinking
// R7: two low bits pick off or clock/768, /1536, /3072
// R8: 1:3 and 1:4 modes always use normal blinking
// R9: alternate-bank blinking swaps output bank at blink rate
// R10: oscillator enable low runs internal clock, driven out on pin
// R11: oscillator enable high takes clock pin as input
// R12: system must keep a clock running at all times
// R13: frame signal runs at selected clock over 24
// R14: cascaded drivers align frames through shared sync pin
// R15: host may blink at other rates by toggling display enable
// R16: bit7 set means next byte is command, clear means data follows
// R17: drive mode 01 static, 10 1:2, 11 1:3, 00 1:4
// R18: normal blink blanks alternate half-periods, known phase at reset
module lcb_core #(
    parameter int FRAME_DIV = `LCB_FRAME_DIV
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic byte_valid_i,
    input wire logic [7:0] byte_i,
    input wire logic xfer_start_i,
    input wire logic osc_enable_pin_i,
    input wire logic osc_tick_i,
    input wire logic clk_pin_i,
    output logic clk_pin_o,
    output logic clk_pin_oe_o,
    input wire logic sync_n_i,
    output logic sync_n_o,
    output logic sync_n_oe_o,
    output logic data_byte_o,
    output logic [5:0] ram_ptr_o,
    output logic [1:0] subaddr_o,
    output lcb_pkg::lcb_drive_e drive_mode_o,
    output logic display_en_o,
    output logic bias_half_o,
    output logic in_bank_o,
    output logic out_bank_o,
    output logic bank_blink_sel_o,
    output logic [1:0] blink_rate_sel_o,
    output logic frame_tick_o,
    output logic blank_o
);
    import lcb_pkg::*;

    // ==========================================================
    // pin synchronisers
    logic [1:0] osc_sync_q;
    logic [2:0] clk_sync_q;
    logic [2:0] sync_sync_q;
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            osc_sync_q <= 2'h0;
            clk_sync_q <= 3'h0;
            sync_sync_q <= 3'h7;
        end else begin
            osc_sync_q <= {osc_sync_q[0], osc_enable_pin_i};
            clk_sync_q <= {clk_sync_q[1:0], clk_pin_i};
            sync_sync_q <= {sync_sync_q[1:0], sync_n_i};
        end
    end

    // ==========================================================
    // clock source select
    logic ext_sel;
    logic lcd_tick;
    always_comb begin
        ext_sel = osc_sync_q[1]; // R11
        // rising edge of the external clock, read past the sync stages
        if (ext_sel) begin
            lcd_tick = clk_sync_q[1] & ~clk_sync_q[2]; // R11
        end else begin
            lcd_tick = osc_tick_i; // R10
        end
    end

    logic clk_out_d, clk_out_q;
    always_comb begin
        // one pin rise per oscillator tick keeps cascaded drivers on the
        // same rate; ticks must be two or more cycles apart to show edges
        clk_out_d = osc_tick_i;
    end
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            clk_out_q <= 1'b0;
        end else begin
            clk_out_q <= clk_out_d;
        end
    end
    assign clk_pin_o = clk_out_q; // R10
    assign clk_pin_oe_o = ~ext_sel; // R10

    // ==========================================================
    // command decoder
    lcb_state_e st_q, st_d;
    logic [5:0] ptr_q, ptr_d;
    logic [1:0] sub_q, sub_d;
    logic [1:0] mode_q, mode_d;
    logic en_q, en_d, bias_q, bias_d;
    logic inb_q, inb_d, outb_q, outb_d;
    logic ab_q, ab_d;
    logic [1:0] bf_q, bf_d;
    logic mux34;
    always_comb begin
        st_d = st_q;
        ptr_d = ptr_q;
        sub_d = sub_q;
        mode_d = mode_q;
        en_d = en_q;
        bias_d = bias_q;
        inb_d = inb_q;
        outb_d = outb_q;
        ab_d = ab_q;
        bf_d = bf_q;
        mux34 = (mode_q == LCB_DRV_MUX3) || (mode_q == LCB_DRV_MUX4);
        if (xfer_start_i) begin
            st_d = LCB_ST_CMD;
        end else if (byte_valid_i && st_q == LCB_ST_CMD) begin
            if (!byte_i[`LCB_CONT_BIT]) begin
                st_d = LCB_ST_DATA; // R16
            end
            if (!byte_i[6]) begin
                ptr_d = byte_i[5:0]; // R1
            end else if (byte_i[6:5] == `LCB_OP_MODE) begin
                en_d = byte_i[`LCB_MODE_EN_BIT]; // R15
                bias_d = byte_i[`LCB_MODE_BIAS_BIT];
                mode_d = byte_i[1:0]; // R17
            end else if (byte_i[6:2] == `LCB_OP_SEL) begin
                sub_d = byte_i[1:0]; // R2
            end else if (byte_i[6:2] == `LCB_OP_BANK) begin
                if (!mux34) begin // R5
                    inb_d = byte_i[`LCB_BANK_IN_BIT]; // R3
                    outb_d = byte_i[`LCB_BANK_OUT_BIT]; // R4
                end
            end else if (byte_i[6:3] == `LCB_OP_BLINK) begin
                ab_d = byte_i[`LCB_BLINK_AB_BIT]; // R6
                bf_d = byte_i[1:0]; // R7
            end
        end
    end
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st_q <= LCB_ST_CMD;
            ptr_q <= 6'h00;
            sub_q <= 2'h0;
            mode_q <= `LCB_RST_MODE;
            en_q <= 1'b0;
            bias_q <= 1'b0;
            inb_q <= 1'b0;
            outb_q <= 1'b0;
            ab_q <= 1'b0;
            bf_q <= 2'h0;
        end else begin
            st_q <= st_d;
            ptr_q <= ptr_d;
            sub_q <= sub_d;
            mode_q <= mode_d;
            en_q <= en_d;
            bias_q <= bias_d;
            inb_q <= inb_d;
            outb_q <= outb_d;
            ab_q <= ab_d;
            bf_q <= bf_d;
        end
    end
    // data strobe is a handshake-style output, so combinational
    assign data_byte_o = byte_valid_i & (st_q == LCB_ST_DATA) & ~xfer_start_i;
    assign ram_ptr_o = ptr_q;
    assign subaddr_o = sub_q;
    assign drive_mode_o = lcb_drive_e'(mode_q);
    assign display_en_o = en_q;
    assign bias_half_o = bias_q;
    assign in_bank_o = inb_q;
    assign bank_blink_sel_o = ab_q;
    assign blink_rate_sel_o = bf_q;

    // ==========================================================
    // frame and blink timing; two counters on the same tick keep rates locked
    localparam int FW = $clog2(FRAME_DIV);
    // half of the fastest blink period; slower rates double it
    localparam int PW = $clog2(`LCB_BLINK_DIV1 / 2);
    logic [FW-1:0] fcnt_q, fcnt_d;
    logic [PW-1:0] bpre_q, bpre_d;
    logic [2:0] bhalf_q, bhalf_d;
    logic frame_q, frame_d;
    logic sync_out_d, sync_out_q;
    logic [1:0] own_q, own_d;
    logic sync_fall;
    logic half_lo;
    always_comb begin
        fcnt_d = fcnt_q;
        bpre_d = bpre_q;
        bhalf_d = bhalf_q;
        frame_d = 1'b0;
        sync_out_d = sync_out_q;
        own_d = {own_q[0], sync_out_q};
        // only a fall we did not cause restarts the frame; own_q delays
        // our own pull so that it lines up with the synchroniser
        sync_fall = ~sync_sync_q[1] & sync_sync_q[2] & own_q[1]; // R14
        if (sync_fall) begin
            fcnt_d = '0; // R14
        end else if (lcd_tick) begin
            if (fcnt_q == FW'(FRAME_DIV - 1)) begin
                fcnt_d = '0;
                frame_d = 1'b1; // R13
            end else begin
                fcnt_d = fcnt_q + 1'b1;
            end
            if (bpre_q == PW'(`LCB_BLINK_DIV1 / 2 - 1)) begin
                bpre_d = '0;
                bhalf_d = bhalf_q + 3'h1; // R7
            end else begin
                bpre_d = bpre_q + 1'b1;
            end
            if (fcnt_q == '0) begin
                sync_out_d = 1'b0; // R14
            end else begin
                sync_out_d = 1'b1;
            end
        end
        // each bit of the half-period count flips at one blink rate
        unique case (bf_q)
            2'h1: half_lo = bhalf_q[0]; // R7
            2'h2: half_lo = bhalf_q[1]; // R7
            2'h3: half_lo = bhalf_q[2]; // R7
            2'h0: half_lo = 1'b0;
        endcase
    end
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            fcnt_q <= '0;
            bpre_q <= '0; // R18
            bhalf_q <= 3'h0; // R18
            frame_q <= 1'b0;
            sync_out_q <= 1'b1;
            own_q <= 2'h3;
        end else begin
            fcnt_q <= fcnt_d;
            bpre_q <= bpre_d;
            bhalf_q <= bhalf_d;
            frame_q <= frame_d;
            sync_out_q <= sync_out_d;
            own_q <= own_d;
        end
    end
    assign frame_tick_o = frame_q;
    // open-drain style: drive only while pulling low
    assign sync_n_o = 1'b0;
    assign sync_n_oe_o = ~sync_out_q; // R14

    logic alt_mode;
    assign alt_mode = ab_q & ~mux34; // R8
    assign out_bank_o = outb_q ^ (alt_mode & half_lo); // R9
    assign blank_o = ~en_q | (~alt_mode & half_lo); // R18
endmodule
`default_nettype wire

// File: src/lcb_pkg.sv
// types shared by the command and blink timing block
// assumes the constants header is included beside it
package lcb_pkg;
    typedef enum logic [1:0] {
        LCB_DRV_MUX4 = 2'b00,
        LCB_DRV_STATIC = 2'b01,
        LCB_DRV_MUX2 = 2'b10,
        LCB_DRV_MUX3 = 2'b11
    } lcb_drive_e;
    typedef enum logic [0:0] {
        LCB_ST_CMD = 1'b0,
        LCB_ST_DATA = 1'b1
    } lcb_state_e;
endpackage

// File: verif/lcb_clk_src.sv
// model of the clock sources: oscillator ticks and an external clock
// assumes ext_sel_i follows the oscillator-enable pin
`timescale 1ns/10ps
`default_nettype none
module lcb_clk_src #(parameter int TK = 2) (
    input wire logic clk_i,
    input wire logic ext_sel_i,
    output logic osc_tick_o,
    output logic ext_clk_o
);
    int cnt = 0;
    initial {osc_tick_o, ext_clk_o} = 2'b00;
    // free running: a stopped clock would leave the lcd at dc
    always @(posedge clk_i) begin
        cnt <= (cnt + 1) % TK;
        osc_tick_o <= !ext_sel_i && cnt == 0;
        ext_clk_o <= ext_sel_i && cnt == 0 ? !ext_clk_o : ext_clk_o;
    end
endmodule
`default_nettype wire

// File: verif/lcb_core_props.sv
// checker: command decode, bank gating and clock pin select
// assumes a bind onto the core and a settled oscillator-enable pin
`timescale 1ns/10ps
`default_nettype none
module lcb_core_props (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic byte_valid_i,
    input wire logic [7:0] byte_i,
    input wire logic xfer_start_i,
    input wire logic osc_enable_pin_i,
    input wire logic clk_pin_oe_o,
    input wire logic data_byte_o,
    input wire logic [5:0] ram_ptr_o,
    input wire logic [1:0] subaddr_o,
    input wire lcb_pkg::lcb_drive_e drive_mode_o,
    input wire logic in_bank_o,
    input wire logic bank_blink_sel_o,
    input wire logic [1:0] blink_rate_sel_o
);
    import lcb_pkg::*;
    // data bytes pulse data_byte_o, so a taken command is any other byte
    wire logic cmd = byte_valid_i && !xfer_start_i && !data_byte_o;
    wire logic bank = cmd && byte_i[6:2] == 5'h1E;
    wire logic mux = !(^drive_mode_o);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    a_ptr_load: assert property (cmd && !byte_i[6] |=>
        ram_ptr_o == $past(byte_i[5:0])) else $error("pointer not loaded");
    a_sub_load: assert property (cmd && byte_i[6:2] == 5'h18 |=>
        subaddr_o == $past(byte_i[1:0])) else $error("subaddress wrong");
    a_bank_load: assert property (bank && !mux |=>
        in_bank_o == $past(byte_i[1])) else $error("input bank wrong");
    a_bank_hold: assert property (bank && mux |=> $stable(in_bank_o))
        else $error("bank taken in 1:3 or 1:4");
    a_blink_load: assert property (cmd && byte_i[6:3] == 4'hE |=>
        {bank_blink_sel_o, blink_rate_sel_o} == $past(byte_i[2:0]))
        else $error("blink select wrong");
    a_data_next: assert property (cmd && !byte_i[7] ##1 byte_valid_i
        && !xfer_start_i |-> data_byte_o) else $error("data byte missed");
    a_osc_int: assert property (!osc_enable_pin_i [*4] |-> clk_pin_oe_o)
        else $error("clock pin not driven");
    a_osc_ext: assert property (osc_enable_pin_i [*4] |-> !clk_pin_oe_o)
        else $error("clock pin still driven");
    c_data: cover property (data_byte_o);
    c_bank_ign: cover property (bank && mux);
    c_ext: cover property (!clk_pin_oe_o);
endmodule
bind lcb_core lcb_core_props u_props (.*);
`default_nettype wire

// File: verif/tb_lcd_command_and_blink_timing.sv
// bench: commands, bank gating, blink rates, clock select, frame rate
// assumes the clock source model and the bound checker alongside
`timescale 1ns/10ps
`default_nettype none
`include "lcb_consts.svh"
module tb_lcd_command_and_blink_timing;
    import lcb_pkg::*;
    localparam int TK = 2;
    logic clk_i = 0, reset_n_i = 0, byte_valid_i = 0, xfer_start_i = 0;
    logic osc_enable_pin_i = 0, osc_tick_i, ext, clk_pin_o, clk_pin_oe_o;
    logic sync_n_o, sync_n_oe_o, data_byte_o, display_en_o, bias_half_o;
    logic in_bank_o, out_bank_o, bank_blink_sel_o, frame_tick_o, blank_o;
    logic [7:0] byte_i = 8'h00;
    logic [5:0] ram_ptr_o;
    logic [1:0] subaddr_o, blink_rate_sel_o;
    lcb_drive_e drive_mode_o;
    int fails = 0, cmp_count = 0, n = 0;
    wire logic clk_pin_i = clk_pin_oe_o ? clk_pin_o : ext;
    // sync line has a pull-up when nobody pulls it low
    wire logic sync_n_i = sync_n_oe_o ? sync_n_o : 1'b1;
    lcb_core DUT (.*);
    lcb_clk_src #(.TK(TK)) SRC (.clk_i, .ext_sel_i(osc_enable_pin_i),
        .osc_tick_o(osc_tick_i), .ext_clk_o(ext));
    initial forever #2 clk_i = ~clk_i;
    initial begin
        #400000;
        fails++;
        finish_test();
    end
    task automatic chk(input string s, input logic [15:0] v, e);
        cmp_count++;
        if (v !== e) begin
            fails++;
            $display("MISMATCH %s exp %h seen %h", s, e, v);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic rst(input logic o);
        @(negedge clk_i);
        osc_enable_pin_i = o;
        reset_n_i = 0;
        repeat (4) @(negedge clk_i);
        reset_n_i = 1;
        repeat (4) @(negedge clk_i);
    endtask
    task automatic start();
        @(negedge clk_i);
        byte_valid_i = 0;
        xfer_start_i = 1;
    endtask
    task automatic send(input logic [7:0] b);
        @(negedge clk_i);
        xfer_start_i = 0;
        byte_valid_i = 1;
        byte_i = b;
    endtask
    task automatic step();
        @(negedge clk_i);
        byte_valid_i = 0;
        n++;
    endtask
    function automatic logic pick(input int s);
        case (s)
            0: return blank_o;
            1: return out_bank_o;
            2: return frame_tick_o;
            3: return clk_pin_o;
            default: return sync_n_oe_o;
        endcase
    endfunction
    // rise to rise; the first period after a change may be partial
    task automatic meas(input int s);
        repeat (3) begin
            n = 0;
            while (pick(s) === 1'b1 && n < 30000) step();
            while (pick(s) !== 1'b1 && n < 30000) step();
        end
    endtask
    task automatic t_cmds();
        start();
        send(8'hA7);
        send(8'hE2);
        chk("ptr", ram_ptr_o, 39);
        send(8'hFB);
        send(8'h05);
        send(8'h33);
        #1;
        chk("data", data_byte_o, 1);
        step();
        chk("ptr", ram_ptr_o, 5);
        chk("sub", subaddr_o, 2);
        chk("in", in_bank_o, 1);
        chk("out", out_bank_o, 1);
    endtask
    task automatic t_mux4();
        start();
        send(8'hCC);
        send(8'hF5);
        send(8'h78);
        step();
        chk("mode", drive_mode_o, LCB_DRV_MUX4);
        chk("bias", bias_half_o, 1);
        chk("in", in_bank_o, 1);
        chk("ab", bank_blink_sel_o, 1);
        meas(0);
        chk("blank", 16'(n), 16'(`LCB_BLINK_DIV1 * TK));
        chk("out", out_bank_o, 1);
    endtask
    task automatic t_rates();
        start();
        send(8'hC9);
        send(8'hF8);
        for (int r = 1; r < 4; r++) begin
            send(8'hF0 | 8'(r));
            step();
            meas(0);
            chk("rate", blink_rate_sel_o, 16'(r));
            chk("blink", 16'(n), 16'((`LCB_BLINK_DIV1 << (r - 1)) * TK));
        end
        send(8'hC1);
        step();
        chk("en", display_en_o, 0);
        chk("off", blank_o, 1);
        send(8'hC9);
        send(8'h75);
        step();
        meas(1);
        chk("swap", 16'(n), 16'(`LCB_BLINK_DIV1 * TK));
        chk("blank", blank_o, 0);
    endtask
    task automatic t_clock();
        chk("oe", clk_pin_oe_o, 1);
        meas(2);
        chk("frame", 16'(n), 16'(`LCB_FRAME_DIV * TK));
        meas(3);
        chk("clk", 16'(n), 16'(TK));
        meas(4);
        chk("sync", 16'(n), 16'(`LCB_FRAME_DIV * TK));
        rst(1);
        chk("oe", clk_pin_oe_o, 0);
        meas(2);
        chk("frame", 16'(n), 16'(`LCB_FRAME_DIV * 2 * TK));
    endtask
    initial begin
        rst(0);
        t_cmds();
        t_mux4();
        t_rates();
        t_clock();
        finish_test();
    end
endmodule
`default_nettype wire
